/* logic/paop_top.sv */
// Output port of a pipelined ADC with a Wishbone register slave
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module paop_top
    import paop_pkg::*;
#(
    parameter int IN_W = 16
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Converter side
    input  wire logic                          adc_clk_i,
    input  wire logic signed [IN_W-1:0]        analog_sample_i,
    input  wire logic                          output_enable_n_i,
    input  wire logic                          code_format_select_i,
    input  wire logic                          reference_source_select_i,
    output logic         [DATA_W-1:0]          sample_data_o,
    output logic         [DATA_W-1:0]          sample_data_oe_o,
    output logic                               sample_ready_strobe_o,
    output logic                               over_range_o,
    output logic                               internal_ref_enable_o,
    // Register bus
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic    [paop_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic    [3:0]                 wb_sel_i,
    input  wire logic    [31:0]                wb_dat_i,
    output logic         [31:0]                wb_dat_o,
    output logic                               wb_ack_o,
    output logic                               irq_o
);
    import paop_pkg::*;

    localparam int WORD_W = DATA_W + 1;

    //--------------------------------------------------------------------------
    // Converter clock edges
    //--------------------------------------------------------------------------
    logic adc_clk_q;
    logic adc_clk_d;
    logic clk_rise;
    logic clk_fall;

    // Previous level of the converter clock; reset matches its idle low
    always_comb begin
        adc_clk_d = adc_clk_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            adc_clk_q <= 1'b0;
        end else begin
            adc_clk_q <= adc_clk_d;
        end
    end

    assign clk_rise = adc_clk_i & ~adc_clk_q;
    assign clk_fall = ~adc_clk_i & adc_clk_q;

    //--------------------------------------------------------------------------
    // Front end and pipeline
    //--------------------------------------------------------------------------
    logic [DATA_W-1:0] coded;
    logic              coded_over;
    logic [WORD_W-1:0] pipe_out;
    logic              capture_en_q;
    logic              capture_en_d;

    paop_coder #(
        .IN_W                 (IN_W)
    ) u_coder (
        .sample_i             (analog_sample_i),
        .code_format_select_i (code_format_select_i),
        .code_o               (coded),
        .over_o               (coded_over)
    );

    // Stage count less one gives whole cycles; the fall-edge update adds the high time
    paop_pipe #(
        .WIDTH   (WORD_W),
        .STAGES  (PIPE_STAGES)
    ) u_pipe (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .flush_i (~capture_en_q),
        .shift_i (clk_rise & capture_en_q),
        .data_i  ({coded_over, coded}),
        .data_o  (pipe_out)
    );

    //--------------------------------------------------------------------------
    // Fill tracking
    //--------------------------------------------------------------------------
    paop_state_e       state_q;
    paop_state_e       state_d;
    logic [FILL_W-1:0] fill_q;
    logic [FILL_W-1:0] fill_d;

    always_comb begin
        state_d = state_q;
        fill_d  = fill_q;
        case (state_q)
            PAOP_IDLE: begin
                fill_d = '0;
                if (capture_en_q) begin
                    state_d = PAOP_FILL;
                end
            end
            PAOP_FILL: begin
                if (!capture_en_q) begin
                    state_d = PAOP_IDLE;
                end else begin
                    if (clk_rise && fill_q != FILL_DONE) begin
                        fill_d = fill_q + 1'b1;
                    end
                    // First valid word leaves on the fall after the last fill rise
                    if (clk_fall && fill_q == FILL_DONE) begin
                        state_d = PAOP_RUN;
                    end
                end
            end
            PAOP_RUN: begin
                if (!capture_en_q) begin
                    state_d = PAOP_IDLE;
                end
            end
            default: begin
                state_d = PAOP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= PAOP_IDLE;
            fill_q  <= '0;
        end else begin
            state_q <= state_d;
            fill_q  <= fill_d;
        end
    end

    //--------------------------------------------------------------------------
    // Output word, ready, over-range and enables
    //--------------------------------------------------------------------------
    logic              word_load;
    logic [DATA_W-1:0] data_q;
    logic [DATA_W-1:0] data_d;
    logic              over_q;
    logic              over_d;
    logic              ready_q;
    logic              ready_d;
    logic              oe_q;
    logic              oe_d;
    logic              refint_q;
    logic              refint_d;

    assign word_load = clk_fall & (state_d == PAOP_RUN);

    always_comb begin
        data_d = data_q;
        over_d = over_q;
        if (state_d != PAOP_RUN) begin
            data_d = '0;
            over_d = 1'b0;
        end else if (word_load) begin
            data_d = pipe_out[DATA_W-1:0];
            over_d = pipe_out[LAST_OVER_BIT];
        end
        // Registered copy of the clock; its fall coincides with the word change
        ready_d  = adc_clk_i & (state_d == PAOP_RUN);
        oe_d     = ~output_enable_n_i;
        // Pin is expected static; only its level is followed
        refint_d = ~reference_source_select_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_q    <= '0;
            over_q    <= 1'b0;
            ready_q   <= 1'b0;
            oe_q      <= 1'b0;
            refint_q  <= 1'b0;
        end else begin
            data_q    <= data_d;
            over_q    <= over_d;
            ready_q   <= ready_d;
            oe_q      <= oe_d;
            refint_q  <= refint_d;
        end
    end

    assign sample_data_o         = data_q;
    assign sample_data_oe_o      = {DATA_W{oe_q}};
    assign sample_ready_strobe_o = ready_q;
    assign over_range_o          = over_q;
    assign internal_ref_enable_o = refint_q;

    //--------------------------------------------------------------------------
    // Register slave and interrupts
    //--------------------------------------------------------------------------
    logic             req;
    logic             wr_ctrl;
    logic             wr_mask;
    logic             rd_irq;
    logic             ack_q;
    logic             ack_d;
    logic [31:0]      rdat_q;
    logic [31:0]      rdat_d;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_stat_d;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_mask_d;
    logic [IRQ_W-1:0] irq_evt;
    logic             irq_q;
    logic             irq_d;

    // One request per ack; ack drops the cycle after it is given
    assign req     = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == CTRL_OFS);
    assign wr_mask = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == IRQ_MASK_OFS);
    assign rd_irq  = req & ~wb_we_i & (wb_adr_i == IRQ_STAT_OFS);

    //--------------------------------------------------------------------------
    // Control registers
    //--------------------------------------------------------------------------
    always_comb begin
        capture_en_d = wr_ctrl ? wb_dat_i[CTRL_EN_BIT] : capture_en_q;
        irq_mask_d   = wr_mask ? wb_dat_i[IRQ_W-1:0] : irq_mask_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            capture_en_q <= CTRL_EN_RESET;
            irq_mask_q   <= IRQ_RESET;
        end else begin
            capture_en_q <= capture_en_d;
            irq_mask_q   <= irq_mask_d;
        end
    end

    //--------------------------------------------------------------------------
    // Sticky interrupt status
    //--------------------------------------------------------------------------
    always_comb begin
        irq_evt               = '0;
        irq_evt[IRQ_WORD_BIT] = word_load;
        irq_evt[IRQ_OVER_BIT] = word_load & pipe_out[LAST_OVER_BIT];
        // A new event in the clearing read survives it
        irq_stat_d            = (rd_irq ? '0 : irq_stat_q) | irq_evt;
        irq_d                 = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_q <= IRQ_RESET;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            irq_q      <= irq_d;
        end
    end

    //--------------------------------------------------------------------------
    // Read data and acknowledge
    //--------------------------------------------------------------------------
    always_comb begin
        ack_d  = req;
        rdat_d = '0;
        if (req && !wb_we_i) begin
            if (wb_adr_i == CTRL_OFS) begin
                rdat_d[CTRL_EN_BIT] = capture_en_q;
            end else if (wb_adr_i == STATUS_OFS) begin
                rdat_d[STAT_READY_BIT]  = ready_q;
                rdat_d[STAT_OVER_BIT]   = over_q;
                rdat_d[STAT_RUN_BIT]    = (state_q == PAOP_RUN);
                rdat_d[STAT_REFINT_BIT] = refint_q;
                rdat_d[STAT_OEN_BIT]    = oe_q;
                rdat_d[STAT_FMT_BIT]    = code_format_select_i;
            end else if (wb_adr_i == LAST_OFS) begin
                rdat_d[DATA_W-1:0]   = data_q;
                rdat_d[LAST_OVER_BIT] = over_q;
            end else if (wb_adr_i == IRQ_STAT_OFS) begin
                rdat_d[IRQ_W-1:0] = irq_stat_q;
            end else if (wb_adr_i == IRQ_MASK_OFS) begin
                rdat_d[IRQ_W-1:0] = irq_mask_q;
            end else begin
                rdat_d = '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o    = irq_q;
endmodule

/* logic/paop_pkg.sv */
// Shared constants, register map and state encoding of the ADC output port
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package paop_pkg;

    localparam int DATA_W        = 14;
    localparam int LATENCY_WHOLE = 7;
    localparam int PIPE_STAGES   = LATENCY_WHOLE + 1;
    localparam int FILL_W        = 4;
    localparam logic [FILL_W-1:0] FILL_DONE = FILL_W'(PIPE_STAGES);

    localparam logic [DATA_W-1:0] CODE_MAX  = 14'h3fff;
    localparam logic [DATA_W-1:0] CODE_MID  = 14'h1fff;
    localparam logic [DATA_W-1:0] CODE_MIN  = 14'h0000;
    localparam logic [DATA_W-1:0] TWOS_FLIP = 14'h2000;

    //--------------------------------------------------------------------------
    // Register map
    //--------------------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] CTRL_OFS     = 8'h00;
    localparam logic [ADR_W-1:0] STATUS_OFS   = 8'h04;
    localparam logic [ADR_W-1:0] LAST_OFS     = 8'h08;
    localparam logic [ADR_W-1:0] IRQ_STAT_OFS = 8'h0c;
    localparam logic [ADR_W-1:0] IRQ_MASK_OFS = 8'h10;

    localparam int CTRL_EN_BIT     = 0;
    localparam logic CTRL_EN_RESET = 1'b1;

    localparam int STAT_READY_BIT  = 0;
    localparam int STAT_OVER_BIT   = 1;
    localparam int STAT_RUN_BIT    = 2;
    localparam int STAT_REFINT_BIT = 3;
    localparam int STAT_OEN_BIT    = 4;
    localparam int STAT_FMT_BIT    = 5;

    localparam int LAST_OVER_BIT = DATA_W;

    localparam int IRQ_W        = 2;
    localparam int IRQ_WORD_BIT = 0;
    localparam int IRQ_OVER_BIT = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    typedef enum logic [2:0] {
        PAOP_IDLE = 3'b001,
        PAOP_FILL = 3'b010,
        PAOP_RUN  = 3'b100
    } paop_state_e;

endpackage

/* logic/paop_coder.sv */
// Converts a signed sample value into a saturated output code
`timescale 1ns/1ps
module paop_coder
    import paop_pkg::*;
#(
    parameter int IN_W = 16
) (
    input  wire logic signed [IN_W-1:0]   sample_i,
    input  wire logic                     code_format_select_i,
    output logic         [DATA_W-1:0]     code_o,
    output logic                          over_o
);
    localparam logic signed [IN_W:0] MID_S = (IN_W+1)'(CODE_MID);
    localparam logic signed [IN_W:0] MAX_S = (IN_W+1)'(CODE_MAX);

    logic signed [IN_W:0] biased;
    logic [DATA_W-1:0]    straight;

    always_comb begin
        biased   = {sample_i[IN_W-1], sample_i} + MID_S;
        straight = biased[DATA_W-1:0];
        over_o   = 1'b0;
        if (biased < 0) begin
            straight = CODE_MIN;
            over_o   = 1'b1;
        end else if (biased > MAX_S) begin
            straight = CODE_MAX;
            over_o   = 1'b1;
        end
        // Zero input lands on mid code in offset binary
        if (code_format_select_i) begin
            code_o = straight;
        end else begin
            code_o = straight ^ TWOS_FLIP;
        end
    end
endmodule

/* logic/paop_pipe.sv */
// Sample pipeline advanced on each converter clock rise while capture is enabled, flushed while it is off
`timescale 1ns/1ps
module paop_pipe #(
    parameter int WIDTH  = 15,
    parameter int STAGES = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             flush_i,
    input  wire logic             shift_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic      [WIDTH-1:0] data_o
);
    logic [WIDTH-1:0] stage_q [STAGES];
    logic [WIDTH-1:0] stage_d [STAGES];

    genvar i;
    generate
        for (i = 0; i < STAGES; i++) begin : g_stage
            always_comb begin
                if (flush_i) begin
                    stage_d[i] = '0;
                end else if (shift_i) begin
                    if (i == 0) begin
                        stage_d[i] = data_i;
                    end else begin
                        stage_d[i] = stage_q[(i == 0) ? 0 : i-1];
                    end
                end else begin
                    stage_d[i] = stage_q[i];
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    stage_q[i] <= '0;
                end else begin
                    stage_q[i] <= stage_d[i];
                end
            end
        end
    endgenerate

    assign data_o = stage_q[STAGES-1];
endmodule

/* verif/paop_assertions.sv */
// Concurrent checks on the pins of the ADC output port
`timescale 1ns/1ps
module paop_chk
    import paop_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              adc_clk_i,
    input  wire logic              output_enable_n_i,
    input  wire logic              reference_source_select_i,
    input  wire logic [DATA_W-1:0] sample_data_o,
    input  wire logic [DATA_W-1:0] sample_data_oe_o,
    input  wire logic              sample_ready_strobe_o,
    input  wire logic              over_range_o,
    input  wire logic              internal_ref_enable_o,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    oe_off_a: assert property ($rose(output_enable_n_i) |=> sample_data_oe_o == '0)
        else $error("data lines still driven after disable");
    oe_on_a: assert property ($fell(output_enable_n_i) |=> &sample_data_oe_o)
        else $error("data lines not driven after enable");
    ready_copy_a: assert property (sample_ready_strobe_o |-> $past(adc_clk_i))
        else $error("ready high without converter clock high");
    ready_track_a: assert property (sample_ready_strobe_o && adc_clk_i |=> sample_ready_strobe_o)
        else $error("ready dropped while converter clock high");
    over_edge_a: assert property ($changed(over_range_o) |->
        !sample_ready_strobe_o && $past(adc_clk_i, 2) && !$past(adc_clk_i))
        else $error("over-range moved away from ready fall");
    word_edge_a: assert property ($changed(sample_data_o) |-> !sample_ready_strobe_o)
        else $error("word changed while ready high");
    ref_follow_a: assert property (!$past(rst_i) |->
        internal_ref_enable_o == !$past(reference_source_select_i))
        else $error("reference enable does not follow select");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged next cycle");
endmodule

bind paop_top paop_chk paop_chk_inst (.clk_i, .rst_i, .adc_clk_i, .output_enable_n_i,
    .reference_source_select_i, .sample_data_o, .sample_data_oe_o, .sample_ready_strobe_o,
    .over_range_o, .internal_ref_enable_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

/* verif/paop_capture.sv */
// Capture-side model: resolves the shared data lines and latches words
`timescale 1ns/1ps
module paop_capture
    import paop_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic [DATA_W-1:0] oe_i,
    input  wire logic              ready_i,
    input  wire logic              over_i,
    output logic      [DATA_W-1:0] word_o,
    output logic                   over_o,
    output logic                   valid_o
);
    logic [DATA_W-1:0] bus_w;
    logic [DATA_W-1:0] last_q = '0;
    logic              rdy_q  = 1'b0;

    // Released lines toggle each cycle so a stale word cannot pass
    assign bus_w = (data_i & oe_i) | (~last_q & ~oe_i);

    always @(posedge clk_i) begin
        last_q  <= bus_w;
        rdy_q   <= ready_i;
        valid_o <= ready_i && !rdy_q;
        word_o  <= bus_w;
        over_o  <= over_i;
    end
endmodule

/* verif/testbench.sv */
// Self-checking bench for the ADC output port
`timescale 1ns/1ps
module testbench;
    import paop_pkg::*;
    logic               clk_i     = 1'b0;
    logic               rst_i     = 1'b1;
    logic               adc_clk_i = 1'b0;
    logic signed [15:0] ana       = '0;
    logic               oen       = 1'b0;
    logic               fmt       = 1'b1;
    logic               refsel    = 1'b0;
    logic               cyc       = 1'b0;
    logic               stb       = 1'b0;
    logic               we        = 1'b0;
    logic [ADR_W-1:0]   adr       = '0;
    logic [31:0]        wdat      = '0;
    logic [DATA_W-1:0]  dat;
    logic [DATA_W-1:0]  oe;
    logic [DATA_W-1:0]  cap_w;
    logic [31:0]        rdat;
    logic [31:0]        r;
    logic               rdy;
    logic               ovr;
    logic               refen;
    logic               ack;
    logic               irq;
    logic               cap_o;
    logic               cap_v;
    int                 n_errors = 0;
    int                 n_tests  = 0;
    int                 exp_q[$];

    always #5 clk_i = ~clk_i;

    paop_top paop_top_inst (.clk_i, .rst_i, .adc_clk_i, .analog_sample_i(ana),
        .output_enable_n_i(oen), .code_format_select_i(fmt),
        .reference_source_select_i(refsel), .sample_data_o(dat), .sample_data_oe_o(oe),
        .sample_ready_strobe_o(rdy), .over_range_o(ovr), .internal_ref_enable_o(refen),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq));

    paop_capture paop_capture_inst (.clk_i, .data_i(dat), .oe_i(oe), .ready_i(rdy),
        .over_i(ovr), .word_o(cap_w), .over_o(cap_o), .valid_o(cap_v));

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic bus(logic w, logic [ADR_W-1:0] a, logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        for (i = 0; i < 20 && ack !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
    endtask

    // Sample value and format settle at the fall, ahead of the next rise
    task automatic run(int n, int hi, int lo, int span);
        int s;
        int b;
        int ov;
        repeat (n) begin
            @(posedge clk_i);
            adc_clk_i <= 1'b1;
            s  = ana;
            b  = s + 32'h1fff;
            ov = (b < 0 || b > 32'h3fff);
            b  = (b < 0) ? 0 : (b > 32'h3fff) ? 32'h3fff : b;
            b  = fmt ? b : b ^ 32'h2000;
            exp_q.push_back(ov * 32'h4000 + b);
            repeat (hi) @(posedge clk_i);
            s = int'($urandom_range(2 * span)) - span;
            adc_clk_i <= 1'b0;
            ana       <= 16'(s);
            fmt       <= 1'($urandom_range(1));
            repeat (lo - 1) @(posedge clk_i);
        end
    endtask

    always @(posedge clk_i) begin
        if (cap_v === 1'b1) begin
            chk({cap_o, cap_w}, exp_q.pop_front());
        end
    end

    initial begin
        r = $urandom(32'h23d3e225);
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, CTRL_OFS, 32'h0);
        chk(r, 32'h1);
        bus(1'b0, IRQ_MASK_OFS, 32'h0);
        chk(r, 32'h0);
        bus(1'b0, 8'h14, 32'h0);
        chk(r, 32'h0);
        $display("test registers done");
        run(12, 3, 3, 9000);
        chk(exp_q.size(), 32'h8);
        chk(irq, 1'b0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(r, {26'h0, fmt, 3'h7, exp_q[0][14], 1'b0});
        bus(1'b0, LAST_OFS, 32'h0);
        chk(r, exp_q[0]);
        bus(1'b1, IRQ_MASK_OFS, 32'h3);
        bus(1'b0, IRQ_MASK_OFS, 32'h0);
        chk(r, 32'h3);
        chk(irq, 1'b1);
        run(16, 2, 5, 8000);
        chk(exp_q.size(), 32'h8);
        $display("test stream done");
        bus(1'b1, CTRL_OFS, 32'h0);
        bus(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(r & 32'h1, 32'h1);
        bus(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(r, 32'h0);
        chk(irq, 1'b0);
        chk(dat, 14'h0);
        $display("test interrupt done");
        oen <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk(oe, 14'h0);
        oen <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(oe, 14'h3fff);
        refsel <= 1'b1;
        bus(1'b0, STATUS_OFS, 32'h0);
        chk(r & 32'h8, 32'h0);
        chk(refen, 1'b0);
        $display("test pins done");
        print_verdict();
    end
endmodule
